// ==== hdl/scie_irq_enable.v ====
// smart card interrupt status, enable and timeout control with ahb-lite slave
// Operation
// - enable bit 14 gates rx count flag
// - enable bit 13 gates tx sent flag
// - enable bit 12 gates guard time error
// - bit 11 sets on wait or delay error
// - status read clears wait time error
// - status read clears flags except rx ready
// - tx sent: set on byte, cleared three ways
// - rx count flag sets on count, read clears
`timescale 1ns/10ps
`default_nettype none
`include "scie_defines.vh"

module scie_sticky (
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire set,
  input wire clr,
  output reg flag
);
  // set beats clear so an event in the clearing cycle survives
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag <= 1'b0;
    end else if (ce) begin
      if (set) begin
        flag <= 1'b1;
      end else if (clr) begin
        flag <= 1'b0;
      end
    end
  end
endmodule // scie_sticky

module scie_irq_enable (
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire rx_count_event,
  input wire tx_byte_done,
  input wire guard_violation,
  input wire wait_violation,
  input wire atr_delay_error,
  input wire rx_begin,
  input wire soft_reset,
  input wire rx_ready_flag,
  output reg irq
);

  // bus decode
  wire addr_phase;
  wire [7:0] addr_lo;
  reg wr_pending;
  reg [7:0] wr_addr;

  // software registers
  reg [31:0] card_irq_enable_reg;
  reg [31:0] timeout_enable_reg;

  // status flags
  wire rx_count_hit;
  wire tx_sent;
  wire block_guard_time_error;
  wire block_wait_time_error;
  wire [31:0] card_irq_status_reg;

  // flag control
  wire status_read;
  wire guard_check_on;
  wire wait_check_on;
  wire auto_switch_on;
  wire set_rx_count;
  wire set_tx_sent;
  wire set_guard;
  wire set_wait;
  wire clr_tx_sent;
  reg [31:0] next_rdata;
  wire next_irq;

  // the slave never inserts wait states on its own; ce low stalls the bus instead
  assign hreadyout = ce;
  assign hresp = 1'b0;

  assign addr_phase = hsel & hready & htrans[1];
  assign addr_lo = haddr[7:0];

  // a status read is recognised in its address phase, so the value
  // returned and the clear come from the same edge
  assign status_read = addr_phase & ~hwrite & (addr_lo == `SCIE_OFS_STATUS);

  assign guard_check_on = timeout_enable_reg[`SCIE_TO_GUARD];
  assign wait_check_on = timeout_enable_reg[`SCIE_TO_WAIT];
  assign auto_switch_on = timeout_enable_reg[`SCIE_TO_AUTO];

  assign set_rx_count = rx_count_event;
  assign set_tx_sent = tx_byte_done;
  // guard errors only count once software has armed the check
  assign set_guard = guard_violation & guard_check_on;
  assign set_wait = (wait_violation & wait_check_on) | atr_delay_error;
  assign clr_tx_sent = status_read | soft_reset | (auto_switch_on & rx_begin);

  scie_sticky u_rx_count (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .set(set_rx_count),
    .clr(status_read),
    .flag(rx_count_hit)
  );

  scie_sticky u_tx_sent (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .set(set_tx_sent),
    .clr(clr_tx_sent),
    .flag(tx_sent)
  );

  scie_sticky u_guard (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .set(set_guard),
    .clr(status_read),
    .flag(block_guard_time_error)
  );

  scie_sticky u_wait (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .set(set_wait),
    .clr(status_read),
    .flag(block_wait_time_error)
  );

  // rx ready is a plain mirror; it only drops when receive data is read
  assign card_irq_status_reg = {17'h0_0000,
                                rx_count_hit,
                                tx_sent,
                                block_guard_time_error,
                                block_wait_time_error,
                                8'h00,
                                rx_ready_flag,
                                2'b00};

  // write data arrives one cycle after the address, so remember the target
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_addr <= 8'h00;
    end else if (ce) begin
      wr_pending <= addr_phase & hwrite;
      if (addr_phase & hwrite) begin
        wr_addr <= addr_lo;
      end
    end
  end

  // reserved enable bits are held at zero, so they can never raise irq
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      card_irq_enable_reg <= `SCIE_EN_RESET;
    end else if (ce) begin
      if (wr_pending && (wr_addr == `SCIE_OFS_ENABLE)) begin
        card_irq_enable_reg <= hwdata & `SCIE_EN_MASK;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timeout_enable_reg <= `SCIE_TO_RESET;
    end else if (ce) begin
      if (wr_pending && (wr_addr == `SCIE_OFS_TIMEOUT)) begin
        timeout_enable_reg <= hwdata & `SCIE_TO_MASK;
      end
    end
  end

  // read mux; unmapped offsets read zero
  always @* begin
    next_rdata = 32'h0000_0000;
    case (addr_lo)
      `SCIE_OFS_STATUS: begin
        next_rdata = card_irq_status_reg;
      end
      `SCIE_OFS_ENABLE: begin
        next_rdata = card_irq_enable_reg;
      end
      `SCIE_OFS_TIMEOUT: begin
        next_rdata = timeout_enable_reg;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // read data is captured at the address phase and held for the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      if (addr_phase & ~hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end

  // each sticky flag reaches irq only through its own enable bit; rx ready never reaches irq
  assign next_irq =
    (rx_count_hit & card_irq_enable_reg[`SCIE_BIT_RX_COUNT]) |
    (tx_sent & card_irq_enable_reg[`SCIE_BIT_TX_SENT]) |
    (block_guard_time_error & card_irq_enable_reg[`SCIE_BIT_GUARD]) |
    (block_wait_time_error & card_irq_enable_reg[`SCIE_BIT_WAIT]);

  // registered so the request line is glitch free, at one cycle of latency
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= next_irq;
    end
  end

endmodule // scie_irq_enable
`default_nettype wire

// ==== hdl/scie_defines.vh ====
// constants for the smart card interrupt enable block
`ifndef SCIE_DEFINES_VH
`define SCIE_DEFINES_VH
`define SCIE_ADDR_W 8
`define SCIE_OFS_STATUS 8'h44
`define SCIE_OFS_ENABLE 8'h48
`define SCIE_OFS_TIMEOUT 8'h4C
`define SCIE_BIT_RX_COUNT 14
`define SCIE_BIT_TX_SENT 13
`define SCIE_BIT_GUARD 12
`define SCIE_BIT_WAIT 11
`define SCIE_BIT_RX_READY 2
`define SCIE_EN_MASK 32'h0000_7800
`define SCIE_EN_RESET 32'h0000_0000
`define SCIE_TO_MASK 32'h0000_0007
`define SCIE_TO_RESET 32'h0000_0000
`define SCIE_TO_GUARD 0
`define SCIE_TO_WAIT 1
`define SCIE_TO_AUTO 2
`define SCIE_HTRANS_NONSEQ 2'b10
`define SCIE_HTRANS_SEQ 2'b11
`endif

// ==== verif/scie_host.sv ====
// host side model: counts interrupt requests
`timescale 1ns/10ps
`default_nettype none
module scie_host (
  input wire hclk,
  input wire irq,
  output logic [7:0] seen
);
  logic last = 1'b0;
  initial seen = 8'h00;
  // a level held high counts once, as an edge-triggered host sees it
  always @(posedge hclk) begin
    last <= irq;
    if (irq && !last) seen <= seen + 8'h01;
  end
endmodule // scie_host
`default_nettype wire

// ==== verif/scie_irq_enable_chk.sv ====
// checker for the smart card interrupt enable block
`timescale 1ns/10ps
`default_nettype none
module scie_chk (
  input wire hclk, hresetn, ce, hsel, hwrite, irq,
  input wire [1:0] htrans,
  input wire [31:0] haddr, hwdata, hrdata,
  input wire rx_count_event, tx_byte_done, guard_violation, atr_delay_error, soft_reset
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [7:0] wa;
  logic [4:0] e;
  wire rd = hsel && htrans[1] && ce && !hwrite;
  // enables snooped off the bus: internals are out of reach
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wa, e} <= 13'h0000;
    end else if (ce) begin
      wa <= hsel && htrans[1] && hwrite ? haddr[7:0] : 8'h00;
      if (wa == 8'h48) e[3:0] <= hwdata[14:11];
      if (wa == 8'h4C) e[4] <= hwdata[0];
    end
  end
  sequence s; ce ##1 ce; endsequence
  property p_rx; (rx_count_event && e[3]) ##0 s |=> irq; endproperty
  a_rx: assert property (p_rx) else $error("no irq");
  property p_tx; (tx_byte_done && e[2]) ##0 s |=> irq; endproperty
  a_tx: assert property (p_tx) else $error("no irq");
  property p_gt; (guard_violation && e[4] && e[1]) ##0 s |=> irq; endproperty
  a_gt: assert property (p_gt) else $error("no irq");
  property p_at; (atr_delay_error && e[0]) ##0 s |=> irq; endproperty
  a_at: assert property (p_at) else $error("no irq");
  property p_of; (ce && e[3:0] == 4'h0) |=> !irq; endproperty
  a_of: assert property (p_of) else $error("stray irq");
  property p_cl; (rd && haddr[7:0] == 8'h44 && e[1:0] == 2'h0 && !rx_count_event
    && !tx_byte_done) ##0 s |=> !irq; endproperty
  a_cl: assert property (p_cl) else $error("irq after read");
  property p_sr; (soft_reset && !tx_byte_done && e[3:0] == 4'h4) ##0 s |=> !irq; endproperty
  a_sr: assert property (p_sr) else $error("irq after soft reset");
  property p_rd; (rd && haddr[7:0] == 8'h48) |=> hrdata[14:11] == $past(e[3:0]); endproperty
  a_rd: assert property (p_rd) else $error("enable readback");
endmodule // scie_chk
bind scie_irq_enable scie_chk u_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
  .hwrite(hwrite), .irq(irq), .htrans(htrans), .haddr(haddr), .hwdata(hwdata), .hrdata(hrdata),
  .rx_count_event(rx_count_event), .tx_byte_done(tx_byte_done), .soft_reset(soft_reset),
  .guard_violation(guard_violation), .atr_delay_error(atr_delay_error));
`default_nettype wire

// ==== verif/smart_card_irq_enable_tb_top.sv ====
// self-checking bench for the smart card interrupt enable block
`timescale 1ns/10ps
`default_nettype none
module smart_card_irq_enable_tb_top;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, dp = 0, ce = 1;
  logic [1:0] htrans = 0;
  logic [7:0] haddr = 0, ev = 0, v, seen;
  logic [31:0] hwdata = 0, w;
  logic [3:0] en = 0, fl = 0;
  logic [32:0] q[$], r;
  wire [31:0] hrdata;
  wire rdy, irq;
  int fail_count = 0, num_checks = 0;
  always #5 hclk = ~hclk;
  scie_irq_enable u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr({24'h00_0000, haddr}), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(rdy), .hreadyout(rdy), .hresp(), .hrdata(hrdata),
    .rx_count_event(ev[0]), .tx_byte_done(ev[1]), .guard_violation(ev[2]),
    .wait_violation(ev[3]), .atr_delay_error(ev[4]), .soft_reset(ev[5]),
    .rx_begin(ev[6]), .rx_ready_flag(ev[7]), .irq(irq));
  scie_host u_host (.hclk(hclk), .irq(irq), .seen(seen));
  // a read notes its expected data and the irq level seen in its data phase
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    if (!wr) q.push_back({|(fl & en), d});
    {haddr, hwrite, hsel, htrans} <= {a, wr, 3'h6};
    do @(posedge hclk); while (rdy !== 1'b1);
    {htrans, hwdata} <= {2'h0, d};
    do @(posedge hclk); while (rdy !== 1'b1);
  endtask
  task automatic pulse(input logic [7:0] p);
    ev <= p;
    @(posedge hclk);
    ev[6:0] <= 7'h00;
    @(posedge hclk);
  endtask
  always @(posedge hclk) begin
    if (dp) begin
      r = q.pop_front();
      num_checks++;
      if ({irq, hrdata} !== r) begin
        $display("unexpected %0t %h %h", $time, {irq, hrdata}, r);
        fail_count++;
      end
    end
    dp <= hsel && htrans[1] && !hwrite;
  end
  task end_sim;
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000 fail_count++;
    end_sim;
  end
  initial begin
    w = $urandom(32'hbe824d34);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    bus(8'h48, 1'b0, 32'h0000_0000);
    for (int i = 0; i < 24; i++) begin
      w = i ? $urandom : 32'h0000_2000;
      en = w[14:11];
      bus(8'h48, 1'b1, w);
      bus(8'h4C, 1'b1, {29'h0000_0000, w[2:0]});
      v = i ? 8'($urandom) : 8'h22;
      pulse(v);
      fl = fl | {v[0], v[1], v[2] & w[0], v[3] & w[1] | v[4]};
      // clears go in a later cycle, since a set wins over a clear
      pulse({v[7:5], 5'h00});
      if (v[5] || v[6] && w[2]) fl[2] = 1'b0;
      bus(8'h48, 1'b0, {17'h0_0000, en, 11'h000});
      bus(8'h44, 1'b0, {17'h0_0000, fl, 8'h00, v[7], 2'h0});
      fl = 4'h0;
    end
    // ce low freezes state: an event in that cycle leaves no flag
    en = 4'hf;
    bus(8'h48, 1'b1, 32'h0000_7800);
    ce <= 1'b0;
    pulse(8'h01);
    ce <= 1'b1;
    bus(8'h44, 1'b0, {17'h0_0000, 4'h0, 8'h00, v[7], 2'h0});
    // a second reset in mid-run wipes flags and enables
    pulse(8'h03);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    en = 4'h0;
    bus(8'h48, 1'b0, 32'h0000_0000);
    bus(8'h44, 1'b0, {17'h0_0000, 4'h0, 8'h00, v[7], 2'h0});
    num_checks++;
    if (seen === 8'h00) begin
      $display("unexpected %0t %h %h", $time, seen, 8'h01);
      fail_count++;
    end
    end_sim;
  end
endmodule // smart_card_irq_enable_tb_top
`default_nettype wire
